// >>> src/dwa_cfg.svh
// Offsets, field positions, reset values and codes of the width aligner
// Function
// RL1: When source and destination widths differ, realign each item, never copy raw words.
// RL2: Conversion holds with both address step enables set; both pointers advance per item.
// RL3: Every item is one source read followed by one destination write; count sets pairs.
// RL4: Byte to byte copies unchanged; both addresses advance by one.
// RL5: Byte to halfword writes the byte zero-extended; destination steps two, source one.
// RL6: Byte to word writes the byte zero-extended to 32 bits; destination steps four.
// RL7: Halfword to byte writes only the low byte; source steps two, destination one.
// RL8: Halfword to halfword copies unchanged; both addresses advance by two.
// RL9: Halfword to word writes the halfword zero-extended; destination steps four.
// RL10: Word to byte writes only the low byte; source steps four, destination one.
// RL11: Word to halfword writes only the low halfword; source four, destination two.
// RL12: Peripheral and memory item widths come from two independent size fields.
// RL13: A set step enable advances that side's address by 1, 2 or 4 per item.
// RL14: Sub-word items sit on byte lanes little-endian, chosen by low address bits.
// RL15: Size fields are two bits: 00 byte, 01 halfword, 10 word, 11 reserved.
`ifndef DWA_CFG_SVH
`define DWA_CFG_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define DWA_OFS_CTRL 5'h00
`define DWA_OFS_PADDR 5'h04
`define DWA_OFS_MADDR 5'h08
`define DWA_OFS_COUNT 5'h0C
`define DWA_OFS_STATUS 5'h10
`define DWA_OFS_CUR_SRC 5'h14
`define DWA_OFS_CUR_DST 5'h18

// ----------------------------------------
// Field positions
// ----------------------------------------
`define DWA_CTRL_START 0
`define DWA_CTRL_DIR 1
`define DWA_CTRL_PW_LSB 2
`define DWA_CTRL_MW_LSB 4
`define DWA_CTRL_PSTEP 6
`define DWA_CTRL_MSTEP 7
`define DWA_STAT_BUSY 0
`define DWA_STAT_DONE 1
`define DWA_STAT_ERR 2
`define DWA_STAT_REM_LSB 16

// ----------------------------------------
// Width codes and reset values
// ----------------------------------------
`define DWA_W_BYTE 2'h0
`define DWA_W_HALF 2'h1
`define DWA_W_WORD 2'h2
`define DWA_ADDR_RST 32'h00000000
`define DWA_WIDTH_RST 2'h0

`endif

// >>> src/dwa_pkg.sv
// Types shared by the width aligner modules
package dwa_pkg;

  typedef logic [1:0] dwa_width_t;

  typedef enum logic [1:0] {
    st_idle,
    st_read,
    st_write
  } dwa_state_t;

endpackage

// >>> src/dwa_buf.sv
// Small valid/ready buffer between read capture and write issue
module dwa_buf #(
  parameter int W = 36,
  parameter int DEPTH = 2
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0] mem_r [DEPTH];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rd_ptr_r;
  logic [CW-1:0] cnt_r;
  logic push;
  logic pop;

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  assign in_ready = (cnt_r != CW'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_r[rd_ptr_r];

  always_ff @(posedge mclk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= ptr_inc(wr_ptr_r);
      end
      if (pop) begin
        rd_ptr_r <= ptr_inc(rd_ptr_r);
      end
      if (push && !pop) begin
        cnt_r <= CW'(cnt_r + 1'b1);
      end else if (pop && !push) begin
        cnt_r <= CW'(cnt_r - 1'b1);
      end
    end
  end

endmodule

// >>> src/dwa_top.sv
// Width converting read-then-write transfer engine with register slave
`include "dwa_cfg.svh"

module dwa_top import dwa_pkg::*; #(
  parameter int CNT_W = 16
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [4:0] s_address,
  input wire logic s_read,
  input wire logic s_write,
  input wire logic [3:0] s_byteenable,
  input wire logic [31:0] s_writedata,
  output logic [31:0] s_readdata,
  output logic s_waitrequest,
  output logic [31:0] m_address,
  output logic m_read,
  output logic m_write,
  output logic [3:0] m_byteenable,
  output logic [31:0] m_writedata,
  input wire logic [31:0] m_readdata,
  input wire logic m_waitrequest,
  output logic busy
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic dir_r;
  dwa_width_t periph_item_width;
  dwa_width_t mem_item_width;
  logic periph_addr_step_en;
  logic mem_addr_step_en;
  logic [31:0] paddr_r;
  logic [31:0] maddr_r;
  logic [CNT_W-1:0] item_count;
  logic done_r;
  logic err_r;
  logic ack_r;
  logic [31:0] s_readdata_r;
  logic start_req_r;
  dwa_state_t state_r;
  logic [31:0] src_cur_r;
  logic [31:0] dst_cur_r;
  logic [CNT_W-1:0] rem_r;
  logic [31:0] m_address_r;
  dwa_width_t src_w;
  dwa_width_t dst_w;
  logic src_step_en;
  logic dst_step_en;
  logic cfg_ok;
  logic reg_wr;
  logic reg_rd_first;
  logic ctrl_wr;
  logic cfg_wr_ok;
  logic rd_done;
  logic wr_done;
  logic last_item;
  logic start_go;
  logic start_bad;
  logic [31:0] src_next;
  logic [31:0] dst_next;
  logic [31:0] rd_mux;
  logic [31:0] item;
  logic buf_in_ready;
  logic buf_out_valid;
  logic [35:0] buf_in_data;
  logic [35:0] buf_out_data;

  // ----------------------------------------
  // Width decoding helpers
  // ----------------------------------------
  function automatic logic [31:0] width_step(input dwa_width_t w);
    unique case (w)
      `DWA_W_BYTE: width_step = 32'h00000001;
      `DWA_W_HALF: width_step = 32'h00000002;
      default: width_step = 32'h00000004;
    endcase
  endfunction

  function automatic logic width_legal(input dwa_width_t w);
    width_legal = (w == `DWA_W_BYTE) || (w == `DWA_W_HALF) || (w == `DWA_W_WORD);
  endfunction

  function automatic logic [3:0] lane_mask(input dwa_width_t w, input logic [1:0] ofs);
    unique case (w)
      `DWA_W_BYTE: lane_mask = 4'(4'h1 << ofs);
      `DWA_W_HALF: lane_mask = ofs[1] ? 4'hC : 4'h3;
      default: lane_mask = 4'hF;
    endcase
  endfunction

  // Pull the addressed item down to bit 0, zero above its width
  function automatic logic [31:0] extract(input logic [31:0] d, input dwa_width_t w,
                                          input logic [1:0] ofs);
    logic [31:0] sh;
    sh = d >> {ofs, 3'h0};
    unique case (w)
      `DWA_W_BYTE: extract = {24'h000000, sh[7:0]};
      `DWA_W_HALF: extract = {16'h0000, sh[15:0]};
      default: extract = sh;
    endcase
  endfunction

  // Copies on every lane; byte enables pick the one that lands
  function automatic logic [31:0] place(input logic [31:0] it, input dwa_width_t w);
    unique case (w)
      `DWA_W_BYTE: place = {4{it[7:0]}};
      `DWA_W_HALF: place = {2{it[15:0]}};
      default: place = it;
    endcase
  endfunction

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    be_merge = r;
  endfunction

  // ----------------------------------------
  // Side selection
  // ----------------------------------------
  // Direction 0 moves peripheral to memory, 1 memory to peripheral
  assign src_w = dir_r ? mem_item_width : periph_item_width; // [RL12]
  assign dst_w = dir_r ? periph_item_width : mem_item_width; // [RL12]
  assign src_step_en = dir_r ? mem_addr_step_en : periph_addr_step_en;
  assign dst_step_en = dir_r ? periph_addr_step_en : mem_addr_step_en;
  assign cfg_ok = width_legal(periph_item_width) && width_legal(mem_item_width); // [RL15]

  // ----------------------------------------
  // Register slave handshake
  // ----------------------------------------
  // Every access waits exactly one cycle, then completes
  assign s_waitrequest = (s_read || s_write) && !ack_r;
  assign s_readdata = s_readdata_r;
  assign reg_wr = s_write && ack_r;
  assign reg_rd_first = s_read && !ack_r;
  assign ctrl_wr = reg_wr && (s_address == `DWA_OFS_CTRL);
  // Config frozen during a transfer so the data path never sees it move
  assign cfg_wr_ok = reg_wr && !busy;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (s_read || s_write) && !ack_r;
    end
  end

  always_comb begin
    rd_mux = 32'h00000000;
    unique case (s_address)
      `DWA_OFS_CTRL: begin
        rd_mux[`DWA_CTRL_DIR] = dir_r;
        rd_mux[`DWA_CTRL_PW_LSB +: 2] = periph_item_width;
        rd_mux[`DWA_CTRL_MW_LSB +: 2] = mem_item_width;
        rd_mux[`DWA_CTRL_PSTEP] = periph_addr_step_en;
        rd_mux[`DWA_CTRL_MSTEP] = mem_addr_step_en;
      end
      `DWA_OFS_PADDR: rd_mux = paddr_r;
      `DWA_OFS_MADDR: rd_mux = maddr_r;
      `DWA_OFS_COUNT: rd_mux[CNT_W-1:0] = item_count;
      `DWA_OFS_STATUS: begin
        rd_mux[`DWA_STAT_BUSY] = busy;
        rd_mux[`DWA_STAT_DONE] = done_r;
        rd_mux[`DWA_STAT_ERR] = err_r;
        rd_mux[`DWA_STAT_REM_LSB +: CNT_W] = rem_r;
      end
      `DWA_OFS_CUR_SRC: rd_mux = src_cur_r;
      `DWA_OFS_CUR_DST: rd_mux = dst_cur_r;
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_readdata_r <= 32'h00000000;
    end else if (reg_rd_first) begin
      s_readdata_r <= rd_mux;
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dir_r <= 1'b0;
      periph_item_width <= `DWA_WIDTH_RST;
      mem_item_width <= `DWA_WIDTH_RST;
      periph_addr_step_en <= 1'b0;
      mem_addr_step_en <= 1'b0;
    end else if (cfg_wr_ok && ctrl_wr && s_byteenable[0]) begin
      dir_r <= s_writedata[`DWA_CTRL_DIR];
      periph_item_width <= s_writedata[`DWA_CTRL_PW_LSB +: 2]; // [RL12]
      mem_item_width <= s_writedata[`DWA_CTRL_MW_LSB +: 2]; // [RL12]
      periph_addr_step_en <= s_writedata[`DWA_CTRL_PSTEP];
      mem_addr_step_en <= s_writedata[`DWA_CTRL_MSTEP];
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      paddr_r <= `DWA_ADDR_RST;
      maddr_r <= `DWA_ADDR_RST;
      item_count <= '0;
    end else if (cfg_wr_ok) begin
      if (s_address == `DWA_OFS_PADDR) begin
        paddr_r <= be_merge(paddr_r, s_writedata, s_byteenable);
      end
      if (s_address == `DWA_OFS_MADDR) begin
        maddr_r <= be_merge(maddr_r, s_writedata, s_byteenable);
      end
      if (s_address == `DWA_OFS_COUNT) begin
        item_count <= CNT_W'(be_merge({{(32 - CNT_W){1'b0}}, item_count},
                                      s_writedata, s_byteenable));
      end
    end
  end

  // Start acts one cycle after the write so it sees the stored fields
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      start_req_r <= 1'b0;
    end else begin
      start_req_r <= cfg_wr_ok && ctrl_wr && s_byteenable[0] &&
                     s_writedata[`DWA_CTRL_START];
    end
  end

  // Reserved width or zero count refuses the start
  assign start_go = start_req_r && cfg_ok && (item_count != '0); // [RL15]
  assign start_bad = start_req_r && !start_go;

  // ----------------------------------------
  // Status flags, set beats a same-cycle clear
  // ----------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      done_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      done_r <= (wr_done && last_item) ||
                (done_r && !(reg_wr && s_address == `DWA_OFS_STATUS &&
                             s_byteenable[0] && s_writedata[`DWA_STAT_DONE]));
      err_r <= start_bad ||
               (err_r && !(reg_wr && s_address == `DWA_OFS_STATUS &&
                           s_byteenable[0] && s_writedata[`DWA_STAT_ERR]));
    end
  end

  assign busy = (state_r != st_idle) || start_req_r;

  // ----------------------------------------
  // Transfer sequencing
  // ----------------------------------------
  // Read only when the buffer can take the item, so a stalled write loses nothing
  assign m_read = (state_r == st_read) && buf_in_ready; // [RL3]
  assign m_write = (state_r == st_write) && buf_out_valid; // [RL3]
  assign rd_done = m_read && !m_waitrequest;
  assign wr_done = m_write && !m_waitrequest;
  assign last_item = (rem_r == CNT_W'(1));
  assign m_address = m_address_r;

  // Each side steps by its own width, only while its step enable is set
  assign src_next = src_step_en ? src_cur_r + width_step(src_w) : src_cur_r; // [RL13] [RL2]
  assign dst_next = dst_step_en ? dst_cur_r + width_step(dst_w) : dst_cur_r; // [RL13] [RL2]

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_r <= st_idle;
    end else begin
      unique case (state_r)
        st_idle: begin
          if (start_go) begin
            state_r <= st_read;
          end
        end
        st_read: begin
          if (rd_done) begin
            state_r <= st_write; // [RL3]
          end
        end
        st_write: begin
          if (wr_done) begin
            state_r <= last_item ? st_idle : st_read; // [RL3]
          end
        end
        default: state_r <= st_idle;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rem_r <= '0;
    end else if (start_go && state_r == st_idle) begin
      rem_r <= item_count;
    end else if (wr_done) begin
      rem_r <= CNT_W'(rem_r - 1'b1); // [RL3]
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      src_cur_r <= `DWA_ADDR_RST;
      dst_cur_r <= `DWA_ADDR_RST;
    end else if (start_go && state_r == st_idle) begin
      src_cur_r <= dir_r ? maddr_r : paddr_r;
      dst_cur_r <= dir_r ? paddr_r : maddr_r;
    end else begin
      if (rd_done) begin
        src_cur_r <= src_next; // [RL4] [RL5] [RL6] [RL7] [RL8] [RL9] [RL10] [RL11]
      end
      if (wr_done) begin
        dst_cur_r <= dst_next; // [RL4] [RL5] [RL6] [RL7] [RL8] [RL9] [RL10] [RL11]
      end
    end
  end

  // Bus address is word aligned; byte enables select the item lanes
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      m_address_r <= `DWA_ADDR_RST;
    end else if (start_go && state_r == st_idle) begin
      m_address_r <= {(dir_r ? maddr_r[31:2] : paddr_r[31:2]), 2'h0};
    end else if (rd_done) begin
      m_address_r <= {dst_cur_r[31:2], 2'h0};
    end else if (wr_done) begin
      m_address_r <= {src_cur_r[31:2], 2'h0};
    end
  end

  // Read byte enables: only the source item lanes
  assign m_byteenable = (state_r == st_write) ? buf_out_data[35:32] :
                        lane_mask(src_w, src_cur_r[1:0]); // [RL14]

  // ----------------------------------------
  // Data realignment
  // ----------------------------------------
  // Truncation to the destination width and zero extension both come from extract
  assign item = extract(extract(m_readdata, src_w, src_cur_r[1:0]), dst_w,
                        2'h0); // [RL1] [RL5] [RL6] [RL7] [RL9] [RL10] [RL11]
  assign buf_in_data = {lane_mask(dst_w, dst_cur_r[1:0]), place(item, dst_w)}; // [RL14] [RL4] [RL8]
  assign m_writedata = buf_out_data[31:0];

  dwa_buf #(
    .W(36),
    .DEPTH(2)
  ) u_buf (
    .mclk(mclk),
    .nrst(nrst),
    .in_valid(rd_done),
    .in_ready(buf_in_ready),
    .in_data(buf_in_data),
    .out_valid(buf_out_valid),
    .out_ready(wr_done),
    .out_data(buf_out_data)
  );

endmodule

// >>> testbench/dwa_props.sv
// Checker for the width aligner master and register bus ports
module dwa_props import dwa_pkg::*; #(
  parameter int CNT_W = 16
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [4:0] s_address,
  input wire logic s_read,
  input wire logic s_write,
  input wire logic [3:0] s_byteenable,
  input wire logic [31:0] s_writedata,
  input wire logic [31:0] s_readdata,
  input wire logic s_waitrequest,
  input wire logic [31:0] m_address,
  input wire logic m_read,
  input wire logic m_write,
  input wire logic [3:0] m_byteenable,
  input wire logic [31:0] m_writedata,
  input wire logic [31:0] m_readdata,
  input wire logic m_waitrequest,
  input wire logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  // ----------------------------------------
  // Master side
  // ----------------------------------------
  one_dir_a: assert property (!(m_read && m_write))
    else $error("master read and write together");
  rd_hold_a: assert property (m_read && m_waitrequest |=> m_read && $stable(m_address))
    else $error("stalled read not held");
  wr_hold_a: assert property (m_write && m_waitrequest |=>
    m_write && $stable(m_address) && $stable(m_writedata) && $stable(m_byteenable))
    else $error("stalled write not held");
  rd_then_wr_a: assert property (m_read && !m_waitrequest |=> m_write && !m_read)
    else $error("read not followed by write");
  wr_gap_a: assert property (m_write && !m_waitrequest |=> !m_write)
    else $error("two writes back to back");
  word_align_a: assert property (m_read || m_write |-> m_address[1:0] == 2'h0)
    else $error("master address not word aligned");
  lane_legal_a: assert property (m_write |-> m_byteenable inside
    {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'hF})
    else $error("illegal write lanes");
  byte_dup_a: assert property (m_write && $onehot(m_byteenable) |->
    m_writedata[31:8] == {3{m_writedata[7:0]}})
    else $error("byte not duplicated on lanes");
  half_dup_a: assert property (m_write && m_byteenable inside {4'h3, 4'hC} |->
    m_writedata[31:16] == m_writedata[15:0])
    else $error("halfword not duplicated on lanes");
  idle_quiet_a: assert property (!busy |-> !m_read && !m_write)
    else $error("master active while idle");
  // A refused start raises busy for one cycle only and moves nothing
  busy_end_a: assert property ($fell(busy) |->
    $past(m_write && !m_waitrequest) || !$past(busy, 2))
    else $error("busy fell without a final write");
  // ----------------------------------------
  // Register side
  // ----------------------------------------
  slv_wait_a: assert property ((s_read || s_write) && s_waitrequest |=> !s_waitrequest)
    else $error("register access not answered in two cycles");
  xfer_c: cover property (m_read && !m_waitrequest ##1 m_write);
  stall_c: cover property (m_write && m_waitrequest);
  done_c: cover property ($fell(busy));
endmodule

bind dwa_top dwa_props #(.CNT_W(CNT_W)) u_props (.mclk(mclk), .nrst(nrst),
  .s_address(s_address), .s_read(s_read), .s_write(s_write), .s_byteenable(s_byteenable),
  .s_writedata(s_writedata), .s_readdata(s_readdata), .s_waitrequest(s_waitrequest),
  .m_address(m_address), .m_read(m_read), .m_write(m_write), .m_byteenable(m_byteenable),
  .m_writedata(m_writedata), .m_readdata(m_readdata), .m_waitrequest(m_waitrequest),
  .busy(busy));

// >>> testbench/dwa_mem_model.sv
// Word memory slave on the master bus with optional one-cycle stall
module dwa_mem_model (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic slow,
  input wire logic [31:0] m_address,
  input wire logic m_read,
  input wire logic m_write,
  input wire logic [3:0] m_byteenable,
  input wire logic [31:0] m_writedata,
  output logic [31:0] m_readdata,
  output logic m_waitrequest
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [16];
  logic held_r;
  logic [31:0] junk_r;
  assign m_waitrequest = slow && (m_read || m_write) && !held_r;
  // Outside a read the bus shows noise, so stale data is never mistaken for good
  assign m_readdata = m_read ? mem[m_address[5:2]] : junk_r;
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      held_r <= 1'b0;
      junk_r <= 32'h5A5A5A5A;
    end else begin
      held_r <= (m_read || m_write) && m_waitrequest;
      junk_r <= ~junk_r + 32'h00000001;
      if (m_write && !m_waitrequest) begin
        for (int b = 0; b < 4; b++) begin
          if (m_byteenable[b]) begin
            mem[m_address[5:2]][8*b +: 8] <= m_writedata[8*b +: 8];
          end
        end
      end
    end
  end
endmodule

// >>> testbench/test_dwa_width_alignment.sv
// Self-checking bench for the width aligner
module test_dwa_width_alignment;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, nrst, s_read, s_write, slow, m_read, m_write, m_waitrequest, busy, s_waitrequest;
  logic [4:0] s_address;
  logic [3:0] s_byteenable, m_byteenable;
  logic [31:0] s_writedata, s_readdata, m_address, m_writedata, m_readdata;
  int miscompares = 0;
  int total_checks = 0;
  int rd_seen, wr_seen;
  dwa_top #(.CNT_W(16)) dut (.mclk(mclk), .nrst(nrst), .s_address(s_address),
    .s_read(s_read), .s_write(s_write), .s_byteenable(s_byteenable),
    .s_writedata(s_writedata), .s_readdata(s_readdata), .s_waitrequest(s_waitrequest),
    .m_address(m_address), .m_read(m_read), .m_write(m_write), .m_byteenable(m_byteenable),
    .m_writedata(m_writedata), .m_readdata(m_readdata), .m_waitrequest(m_waitrequest),
    .busy(busy));
  dwa_mem_model mem (.mclk(mclk), .nrst(nrst), .slow(slow), .m_address(m_address),
    .m_read(m_read), .m_write(m_write), .m_byteenable(m_byteenable),
    .m_writedata(m_writedata), .m_readdata(m_readdata), .m_waitrequest(m_waitrequest));
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (m_read === 1'b1 && m_waitrequest === 1'b0) rd_seen++;
    if (m_write === 1'b1 && m_waitrequest === 1'b0) wr_seen++;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Shared by reads and writes; a wait that never ends closes the run
  task automatic bus_op(input logic wr, input logic [4:0] a, input logic [31:0] d,
                        output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk);
    s_address <= a;
    s_writedata <= d;
    s_write <= wr;
    s_read <= !wr;
    do begin
      @(posedge mclk);
      n++;
    end while (s_waitrequest !== 1'b0 && n < 50);
    q = s_readdata;
    s_write <= 1'b0;
    s_read <= 1'b0;
    if (n >= 50) begin
      miscompares++;
      close_out();
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus_op(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] q);
    bus_op(1'b0, a, 32'h00000000, q);
  endtask
  // Source bytes hold A0 plus their address; destination starts at 0x20, cleared
  // Direction 1 swaps the sides: memory is the source, peripheral the destination
  task automatic run_case(input logic [1:0] pw, input logic [1:0] mw, input logic sl,
                          input logic dr);
    logic [7:0] exp [16];
    logic [31:0] q;
    int sw, dw, n;
    sw = 1 << (dr ? mw : pw);
    dw = 1 << (dr ? pw : mw);
    for (int i = 0; i < 16; i++) exp[i] = 8'h00;
    for (int i = 0; i < 4; i++)
      for (int b = 0; b < dw; b++) exp[i*dw+b] = (b < sw) ? 8'hA0 + 8'(i*sw+b) : 8'h00;
    for (int k = 0; k < 4; k++) begin
      for (int b = 0; b < 4; b++) mem.mem[k][8*b +: 8] = 8'hA0 + 8'(4*k+b);
      mem.mem[8+k] = 32'h00000000;
    end
    slow <= sl;
    rd_seen = 0;
    wr_seen = 0;
    wr(5'h04, dr ? 32'h00000020 : 32'h00000000);
    wr(5'h08, dr ? 32'h00000000 : 32'h00000020);
    wr(5'h0C, 32'h00000004);
    wr(5'h00, {24'h000000, 2'b11, mw, pw, dr, 1'b1});
    @(posedge mclk);
    #1;
    check("busy", {31'h0, busy}, 32'h00000001);
    n = 0;
    do begin
      rd(5'h10, q);
      n++;
    end while (q[1] !== 1'b1 && n < 100);
    if (n >= 100) begin
      miscompares++;
      close_out();
    end
    check("status", {q[31:16], 13'h0, q[2:0]}, 32'h00000002);
    check("reads", rd_seen, 32'h00000004);
    check("writes", wr_seen, 32'h00000004);
    for (int k = 0; k < 4; k++)
      check("dest", mem.mem[8+k], {exp[4*k+3], exp[4*k+2], exp[4*k+1], exp[4*k]});
    rd(5'h14, q);
    check("cur_src", q, 32'(4*sw));
    rd(5'h18, q);
    check("cur_dst", q, 32'h20 + 32'(4*dw));
    wr(5'h10, 32'h00000006);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic sc_from_byte();
    run_case(2'h0, 2'h0, 1'b0, 1'b0);
    run_case(2'h0, 2'h1, 1'b0, 1'b0);
    run_case(2'h0, 2'h2, 1'b1, 1'b0);
  endtask
  task automatic sc_from_half();
    run_case(2'h1, 2'h0, 1'b1, 1'b0);
    run_case(2'h1, 2'h1, 1'b0, 1'b0);
    run_case(2'h1, 2'h2, 1'b0, 1'b0);
  endtask
  task automatic sc_from_word();
    run_case(2'h2, 2'h0, 1'b0, 1'b0);
    run_case(2'h2, 2'h1, 1'b1, 1'b0);
    run_case(2'h2, 2'h2, 1'b0, 1'b0);
  endtask
  // Memory to peripheral: the widths follow the swapped sides
  task automatic sc_reverse();
    run_case(2'h2, 2'h1, 1'b1, 1'b1);
    run_case(2'h0, 2'h2, 1'b0, 1'b1);
  endtask
  // Reset in mid-transfer leaves the engine idle with flags and count clear
  task automatic sc_reset();
    logic [31:0] q;
    wr(5'h0C, 32'h00000004);
    wr(5'h00, 32'h000000C1);
    repeat (3) @(posedge mclk);
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    #1;
    check("rst_busy", {31'h0, busy}, 32'h00000000);
    rd(5'h10, q);
    check("rst_status", q, 32'h00000000);
    rd(5'h0C, q);
    check("rst_count", q, 32'h00000000);
  endtask
  // Reserved width and zero count must move nothing
  task automatic sc_refuse();
    logic [31:0] q;
    rd_seen = 0;
    wr(5'h0C, 32'h00000004);
    wr(5'h00, 32'h000000CD);
    rd(5'h10, q);
    check("err_pw", {29'h0, q[2:0]}, 32'h00000004);
    wr(5'h10, 32'h00000006);
    wr(5'h00, 32'h000000F1);
    rd(5'h10, q);
    check("err_mw", {29'h0, q[2:0]}, 32'h00000004);
    wr(5'h10, 32'h00000006);
    wr(5'h0C, 32'h00000000);
    wr(5'h00, 32'h000000C1);
    rd(5'h10, q);
    check("err_cnt", {29'h0, q[2:0]}, 32'h00000004);
    wr(5'h10, 32'h00000006);
    check("no_reads", rd_seen, 32'h00000000);
    wr(5'h1C, 32'hFFFFFFFF);
    rd(5'h1C, q);
    check("unmapped", q, 32'h00000000);
  endtask
  initial begin
    nrst = 1'b0;
    s_address = 5'h00;
    s_read = 1'b0;
    s_write = 1'b0;
    s_byteenable = 4'hF;
    s_writedata = 32'h00000000;
    slow = 1'b0;
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    sc_from_byte();
    sc_from_half();
    sc_from_word();
    sc_reverse();
    sc_refuse();
    sc_reset();
    close_out();
  end
endmodule
